// file: include/qldp_defines.svh
// Purpose: Register map, field positions and counts for the LO divider
// Assumes: Included by the package, by qldp_phase_gen and qldp_top, and by the tests
// Notes:   Definitions only
`ifndef QLDP_DEFINES_SVH
`define QLDP_DEFINES_SVH

`define QLDP_ADDR_W              12
`define QLDP_DATA_W              8
`define QLDP_ADDR_PHASE          12'h02D
`define QLDP_ADDR_LOCFG          12'h02E

`define QLDP_PHASE_MSB           3
`define QLDP_PHASE_LSB           0
`define QLDP_PHASE_RESET         4'h0
`define QLDP_PHASE_PAD           4'h0

`define QLDP_LOCFG_RATIO_MSB     2
`define QLDP_LOCFG_RATIO_LSB     0
`define QLDP_LOCFG_SYNC_FALL_BIT 3
`define QLDP_LOCFG_PAD           4'h0
`define QLDP_RATIO_CODE_DIV4     3'h0
`define QLDP_RATIO_CODE_DIV8     3'h1
`define QLDP_RATIO_CODE_DIV16    3'h2
`define QLDP_RATIO_CODE_RESET    3'h0
`define QLDP_SYNC_FALL_RESET     1'h0

`define QLDP_CNT_W               4
`define QLDP_CNT_LOAD            4'h0
`define QLDP_CNT_STEP            4'h1
`define QLDP_CNT_TOP_DIV4        4'h3
`define QLDP_CNT_TOP_DIV8        4'h7
`define QLDP_CNT_TOP_DIV16       4'hF
`define QLDP_QUARTER_DIV4        4'h1
`define QLDP_QUARTER_DIV8        4'h2
`define QLDP_QUARTER_DIV16       4'h4
`define QLDP_MSB_DIV4            2'h1
`define QLDP_MSB_DIV8            2'h2
`define QLDP_MSB_DIV16           2'h3
`define QLDP_RDATA_ZERO          8'h00

`endif

// file: include/qldp_pkg.sv
// Purpose: Types shared by the LO divider and phase logic
// Assumes: Constants come from the defines header
// Notes:   Ratio enum is decoded from the three-bit config field
`include "qldp_defines.svh"

package qldp_pkg;

  typedef enum logic [1:0] {
    RATIO_DIV4,
    RATIO_DIV8,
    RATIO_DIV16
  } qldp_ratio_type;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`QLDP_ADDR_W-1:0]   addr;
    logic [`QLDP_DATA_W-1:0]   wdata;
  } qldp_reg_req_type;

endpackage : qldp_pkg

// file: verilog/qldp_sync_capture.sv
// Purpose: Samples the divider sync pin on a chosen LO edge, gives a pulse
// Assumes: sync_pin is asynchronous or launched on the opposite edge
// Notes:   Two full synchronisers, one per edge; selection after them
module qldp_sync_capture
  import qldp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic sync_pin,
  input  wire logic sample_fall,
  output logic      sync_edge
);

  logic rise_s1_r;
  logic rise_s2_r;
  logic fall_s1_r;
  logic fall_s2_r;
  logic fall_rt_r;
  logic sel_prev_r;
  logic sync_edge_r;
  wire  sel_level;

  // Rising-edge sampling chain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rise_s1_r <= 1'h0;
      rise_s2_r <= 1'h0;
    end else begin
      rise_s1_r <= sync_pin;
      rise_s2_r <= rise_s1_r;
    end
  end

  // Falling-edge sampling chain
  always_ff @(negedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fall_s1_r <= 1'h0;
      fall_s2_r <= 1'h0;
    end else begin
      fall_s1_r <= sync_pin;
      fall_s2_r <= fall_s1_r;
    end
  end

  assign sel_level = sample_fall ? fall_rt_r : rise_s2_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fall_rt_r   <= 1'h0;
      sel_prev_r  <= 1'h0;
      sync_edge_r <= 1'h0;
    end else begin
      fall_rt_r   <= fall_s2_r;
      sel_prev_r  <= sel_level;
      sync_edge_r <= sel_level & ~sel_prev_r;
    end
  end

  assign sync_edge = sync_edge_r;

endmodule : qldp_sync_capture

// file: verilog/qldp_phase_gen.sv
// Purpose: One channel's I and Q LO outputs from the shared divider count
// Assumes: cnt steps once per LO clock and wraps at the divide ratio
// Notes:   Half-count steps use a falling-edge retime of an early copy
`include "qldp_defines.svh"
module qldp_phase_gen
  import qldp_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [`QLDP_CNT_W-1:0] cnt,
  input  wire logic [3:0]             code,
  input  wire qldp_ratio_type         ratio,
  output logic                        lo_i,
  output logic                        lo_q
);

  logic [4:0]             half_steps;
  logic [`QLDP_CNT_W-1:0] quarter;
  logic [1:0]             msb;
  wire  [`QLDP_CNT_W-1:0] whole;
  wire                    half;
  wire  [`QLDP_CNT_W-1:0] x_pos;
  wire  [`QLDP_CNT_W-1:0] x_early;
  wire  [`QLDP_CNT_W-1:0] xq_pos;
  wire  [`QLDP_CNT_W-1:0] xq_early;
  logic                   i_pos_r;
  logic                   q_pos_r;
  logic                   i_early_r;
  logic                   q_early_r;
  logic                   i_neg_r;
  logic                   q_neg_r;

  // Code k is k/16 of a turn (odd k rounds down at divide-by-4), expressed here in half LO clocks
  always_comb begin
    case (ratio)
      RATIO_DIV4: begin
        half_steps = {2'h0, code[3:1]};
        quarter    = `QLDP_QUARTER_DIV4;
        msb        = `QLDP_MSB_DIV4;
      end
      RATIO_DIV8: begin
        half_steps = {1'h0, code};
        quarter    = `QLDP_QUARTER_DIV8;
        msb        = `QLDP_MSB_DIV8;
      end
      RATIO_DIV16: begin
        half_steps = {code, 1'h0};
        quarter    = `QLDP_QUARTER_DIV16;
        msb        = `QLDP_MSB_DIV16;
      end
      default: begin
        half_steps = {1'h0, code};
        quarter    = `QLDP_QUARTER_DIV8;
        msb        = `QLDP_MSB_DIV8;
      end
    endcase
  end

  assign whole    = half_steps[4:1];
  assign half     = half_steps[0];
  assign x_pos    = cnt + whole;
  assign x_early  = x_pos + `QLDP_CNT_STEP;
  assign xq_pos   = x_pos - quarter;
  assign xq_early = x_early - quarter;

  // Final flops clocked straight from the LO clock; MSB gives 50% duty
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      i_pos_r   <= 1'h0;
      q_pos_r   <= 1'h0;
      i_early_r <= 1'h0;
      q_early_r <= 1'h0;
    end else begin
      i_pos_r   <= x_pos[msb];
      q_pos_r   <= xq_pos[msb];
      i_early_r <= x_early[msb];
      q_early_r <= xq_early[msb];
    end
  end

  always_ff @(negedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      i_neg_r <= 1'h0;
      q_neg_r <= 1'h0;
    end else begin
      i_neg_r <= i_early_r;
      q_neg_r <= q_early_r;
    end
  end

  assign lo_i = half ? i_neg_r : i_pos_r;
  assign lo_q = half ? q_neg_r : q_pos_r;

endmodule : qldp_phase_gen

// file: verilog/qldp_top.sv
// Purpose: CW LO divide-by-M quadrature generator with per-channel phase
// Assumes: ref_clk is the multi-rate LO clock; register port is on it
// Notes:   Ratio and phase changes take effect at a divider wrap or sync
`include "qldp_defines.svh"
module qldp_top
  import qldp_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire qldp_reg_req_type        reg_req,
  input  wire logic [NUM_CH-1:0]       chan_sel,
  output logic [`QLDP_DATA_W-1:0]      reg_rdata,
  input  wire logic                    sync_pin,
  output logic [NUM_CH-1:0]            lo_i,
  output logic [NUM_CH-1:0]            lo_q
);

  // Register decode
  wire                        hit_phase;
  wire                        hit_locfg;
  wire                        wr_phase;
  wire                        wr_locfg;
  wire                        rd_phase;
  wire                        rd_locfg;
  wire  [2:0]                 wr_ratio_code;
  wire                        wr_code_valid;

  // Configuration storage
  logic [2:0]                 ratio_code_r;
  logic                       sync_fall_r;
  logic [3:0]                 phase_r     [NUM_CH];
  logic [3:0]                 phase_act_r [NUM_CH];
  qldp_ratio_type             ratio_cfg;
  qldp_ratio_type             ratio_act_r;

  // Divider state
  logic [`QLDP_CNT_W-1:0]     cnt_r;
  logic [`QLDP_CNT_W-1:0]     cnt_nxt;
  logic [`QLDP_CNT_W-1:0]     cnt_top;
  wire                        cnt_wrap;
  wire                        sync_edge;
  wire                        apply_cfg;

  // Read path
  logic [3:0]                 rd_phase_code;
  logic [`QLDP_DATA_W-1:0]    rdata_nxt;
  logic [`QLDP_DATA_W-1:0]    rdata_r;

  assign hit_phase = (reg_req.addr == `QLDP_ADDR_PHASE);
  assign hit_locfg = (reg_req.addr == `QLDP_ADDR_LOCFG);
  assign wr_phase  = reg_req.wr & hit_phase;
  assign wr_locfg  = reg_req.wr & hit_locfg;
  assign rd_phase  = reg_req.rd & hit_phase;
  assign rd_locfg  = reg_req.rd & hit_locfg;

  assign wr_ratio_code =
    reg_req.wdata[`QLDP_LOCFG_RATIO_MSB:`QLDP_LOCFG_RATIO_LSB];

  assign wr_code_valid = (wr_ratio_code == `QLDP_RATIO_CODE_DIV4)
                       | (wr_ratio_code == `QLDP_RATIO_CODE_DIV8)
                       | (wr_ratio_code == `QLDP_RATIO_CODE_DIV16);

  // LO config register: ratio code only replaced by a valid code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ratio_code_r <= `QLDP_RATIO_CODE_RESET;
      sync_fall_r  <= `QLDP_SYNC_FALL_RESET;
    end else if (wr_locfg) begin
      if (wr_code_valid) begin
        ratio_code_r <= wr_ratio_code;
      end
      sync_fall_r <= reg_req.wdata[`QLDP_LOCFG_SYNC_FALL_BIT];
    end
  end

  // Stored code to ratio
  always_comb begin
    case (ratio_code_r)
      `QLDP_RATIO_CODE_DIV4:  ratio_cfg = RATIO_DIV4;
      `QLDP_RATIO_CODE_DIV8:  ratio_cfg = RATIO_DIV8;
      `QLDP_RATIO_CODE_DIV16: ratio_cfg = RATIO_DIV16;
      default:                ratio_cfg = RATIO_DIV4;
    endcase
  end

  // Per-channel phase registers; a write reaches every selected channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_phase_reg
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          phase_r[ch] <= `QLDP_PHASE_RESET;
        end else if (wr_phase && chan_sel[ch]) begin
          phase_r[ch] <=
            reg_req.wdata[`QLDP_PHASE_MSB:`QLDP_PHASE_LSB];
        end
      end

      // Taken into use at a wrap or a sync edge, so an output never changes phase mid-count
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          phase_act_r[ch] <= `QLDP_PHASE_RESET;
        end else if (apply_cfg) begin
          phase_act_r[ch] <= phase_r[ch];
        end
      end
    end
  endgenerate

  // Sync input capture on the selected LO edge
  qldp_sync_capture u_sync (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .sync_pin    (sync_pin),
    .sample_fall (sync_fall_r),
    .sync_edge   (sync_edge)
  );

  // Divider count limit for the ratio in use
  always_comb begin
    case (ratio_act_r)
      RATIO_DIV4:  cnt_top = `QLDP_CNT_TOP_DIV4;
      RATIO_DIV8:  cnt_top = `QLDP_CNT_TOP_DIV8;
      RATIO_DIV16: cnt_top = `QLDP_CNT_TOP_DIV16;
      default:     cnt_top = `QLDP_CNT_TOP_DIV4;
    endcase
  end

  assign cnt_wrap  = (cnt_r >= cnt_top);
  assign apply_cfg = cnt_wrap | sync_edge;

  // A sync pulse every M clocks lands exactly on the natural wrap
  always_comb begin
    if (sync_edge) begin
      cnt_nxt = `QLDP_CNT_LOAD;
    end else if (cnt_wrap) begin
      cnt_nxt = `QLDP_CNT_LOAD;
    end else begin
      cnt_nxt = cnt_r + `QLDP_CNT_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r       <= `QLDP_CNT_LOAD;
      ratio_act_r <= RATIO_DIV4;
    end else begin
      cnt_r <= cnt_nxt;
      if (apply_cfg) begin
        ratio_act_r <= ratio_cfg;
      end
    end
  end

  // Output stages, one per channel, all on the shared count
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      qldp_phase_gen u_gen (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .cnt     (cnt_r),
        .code    (phase_act_r[ch]),
        .ratio   (ratio_act_r),
        .lo_i    (lo_i[ch]),
        .lo_q    (lo_q[ch])
      );
    end
  endgenerate

  // Phase read returns the lowest selected channel
  always_comb begin
    rd_phase_code = `QLDP_PHASE_RESET;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (chan_sel[i]) begin
        rd_phase_code = phase_r[i];
      end
    end
  end

  always_comb begin
    if (rd_phase) begin
      rdata_nxt = {`QLDP_PHASE_PAD, rd_phase_code};
    end else if (rd_locfg) begin
      rdata_nxt = {`QLDP_LOCFG_PAD, sync_fall_r, ratio_code_r};
    end else begin
      rdata_nxt = `QLDP_RDATA_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `QLDP_RDATA_ZERO;
    end else if (reg_req.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : qldp_top

// file: test/qldp_top_sva.sv
// Purpose: Port checks for the LO divider and phase block
// Assumes: Bound to qldp_top, one clock domain
// Notes:   quiet = no write and no sync change for 63 cycles
`include "qldp_defines.svh"
module qldp_top_sva
  import qldp_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire qldp_reg_req_type  reg_req,
  input wire logic [NUM_CH-1:0] chan_sel,
  input wire logic [7:0]        reg_rdata,
  input wire logic              sync_pin,
  input wire logic [NUM_CH-1:0] lo_i,
  input wire logic [NUM_CH-1:0] lo_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] quiet_r;
  logic [3:0] run_r;
  logic       prev_i_r;
  logic       prev_s_r;
  wire        quiet = quiet_r == 6'h3F;
  wire        rd_cfg = reg_req.rd && reg_req.addr == `QLDP_ADDR_LOCFG;
  wire        rd_ph = reg_req.rd && reg_req.addr == `QLDP_ADDR_PHASE;
  wire        rd_bad = reg_req.rd && !rd_cfg && !rd_ph;
  wire        stir = reg_req.wr || sync_pin != prev_s_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      quiet_r  <= 6'h00;
      run_r    <= 4'h0;
      prev_i_r <= 1'b0;
      prev_s_r <= 1'b0;
    end else begin
      prev_i_r <= lo_i[0];
      prev_s_r <= sync_pin;
      quiet_r  <= stir ? 6'h00 : (quiet ? quiet_r : quiet_r + 6'h01);
      run_r    <= lo_i[0] != prev_i_r ? 4'h0
                : run_r + {3'h0, run_r != 4'hF};
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_rdata_hold: assert property (
    !$past(reg_req.rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_upper_zero: assert property (reg_rdata[7:4] == 4'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (
    rd_bad |-> ##1 reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ratio_legal: assert property (
    rd_cfg |-> ##1 reg_rdata[2:0] <= 3'h2)
    else $error("reserved ratio code stored");
  a_nosel_zero: assert property (
    rd_ph && chan_sel == '0 |-> ##1 reg_rdata == 8'h00)
    else $error("phase read without channel not zero");
  a_reset_zero: assert property (
    $rose(rstn) |-> lo_i == '0 && lo_q == '0)
    else $error("LO outputs not cleared by reset");
  a_i_toggles: assert property (quiet |-> run_r < 4'h8)
    else $error("LO output stalled");
  a_q_lags_i: assert property (
    quiet && $rose(lo_q[0]) |-> lo_i[0] && $past(lo_i[0]))
    else $error("Q does not lag I");
  c_sync: cover property ($rose(sync_pin));
  c_cfg_wr: cover property (reg_req.wr && reg_req.addr == `QLDP_ADDR_LOCFG);
  c_run: cover property (quiet && $rose(lo_i[0]));
endmodule : qldp_top_sva

// file: test/qldp_sync_source.sv
// Purpose: Far side: array sync generator on the shared LO clock
// Assumes: ref_clk is the LO clock common to the array
// Notes:   Launches on the LO edge opposite the sampling edge
module qldp_sync_source (
  input  wire logic ref_clk,
  input  wire logic fall_mode,
  output logic      sync_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sync_pin = 1'b0;
  task automatic launch_edge();
    if (fall_mode) @(posedge ref_clk);
    else @(negedge ref_clk);
  endtask : launch_edge
  // One pulse when n is 1, else a train of n pulses m LO clocks apart, common to all devices
  task automatic toggle(input int m, input int n);
    repeat (n) begin
      launch_edge();
      sync_pin <= 1'b1;
      repeat (m / 2) launch_edge();
      sync_pin <= 1'b0;
      repeat (m / 2 - 1) launch_edge();
    end
  endtask : toggle
endmodule : qldp_sync_source

// file: test/test_qldp_top.sv
// Purpose: Self-checking bench for the LO divider and phase block
// Assumes: Sync source model drives the sync pin
// Notes:   Register and LO expectations come from integer models
`include "qldp_defines.svh"
module test_qldp_top
  import qldp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 4;
  logic             ref_clk;
  logic             rstn;
  logic             sync_pin;
  logic             fall_sel;
  qldp_reg_req_type req;
  logic [NCH-1:0]   sel;
  logic [7:0]       rdata;
  logic [NCH-1:0]   lo_i;
  logic [NCH-1:0]   lo_q;
  int               err_count;
  int               checks_done;
  int               ratio_m;
  int               fall_m;
  int               code_m[NCH];

  qldp_top #(.NUM_CH(NCH)) i_qldp_top (.ref_clk(ref_clk), .rstn(rstn),
    .reg_req(req), .chan_sel(sel), .reg_rdata(rdata), .sync_pin(sync_pin),
    .lo_i(lo_i), .lo_q(lo_q));
  qldp_sync_source i_qldp_sync_source (.ref_clk(ref_clk),
    .fall_mode(fall_sel), .sync_pin(sync_pin));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [NCH-1:0] s);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    sel = s;
    @(posedge ref_clk) #1;
    req.wr = 1'b0;
    if (a == `QLDP_ADDR_LOCFG) begin
      if (d[2:0] <= 3'h2) ratio_m = d[2:0];
      fall_m = d[3];
    end
    for (int i = 0; i < NCH; i++) begin
      if (a == `QLDP_ADDR_PHASE && s[i]) code_m[i] = d[3:0];
    end
    @(posedge ref_clk) #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [NCH-1:0] s);
    logic [7:0] e;
    e = 8'h00;
    if (a == `QLDP_ADDR_LOCFG) e = {4'h0, fall_m[0], ratio_m[2:0]};
    for (int i = NCH - 1; i >= 0; i--) begin
      if (a == `QLDP_ADDR_PHASE && s[i]) e = {4'h0, code_m[i][3:0]};
    end
    req.rd = 1'b1;
    req.addr = a;
    sel = s;
    @(posedge ref_clk) #1;
    req.rd = 1'b0;
    @(posedge ref_clk) #1;
    chk(rdata, e);
  endtask : rd

  // Sync train of n periods; every channel looked at after both LO edges,
  // model in half LO clocks; falling-edge sampling loads one clock later
  task automatic lo_run(input int m, input int n, output logic [7:0] pat);
    int h;
    int t;
    fork
      i_qldp_sync_source.toggle(m, n);
    join_none
    repeat (7) @(posedge ref_clk);
    #1;
    for (int j = 2; j < n * m + 2; j++) begin
      for (int e = 0; e < 2; e++) begin
        t = 2 * (j - fall_m) + e;
        for (int c = 0; c < NCH; c++) begin
          h = code_m[c] * m / 8;
          chk(lo_i[c], ((t + h) % (2 * m)) >= m);
          chk(lo_q[c], ((t + h + 2 * m - m / 2) % (2 * m)) >= m);
        end
        if (e == 0 && j < 10) pat[j - 2] = lo_i[0];
        if (e == 0) @(negedge ref_clk) #1;
      end
      @(posedge ref_clk) #1;
    end
  endtask : lo_run

  initial begin
    logic [7:0] p0;
    logic [7:0] p1;
    int         m;
    req = '0;
    sel = '0;
    fall_sel = 1'b0;
    rstn = 1'b0;
    err_count = 0;
    checks_done = 0;
    ratio_m = 0;
    fall_m = 0;
    foreach (code_m[i]) code_m[i] = 0;
    void'($urandom(20461));
    repeat (16) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    rd(`QLDP_ADDR_LOCFG, 1);
    rd(`QLDP_ADDR_PHASE, 1);
    for (int k = 0; k < 24; k++) begin
      wr(k % 3 == 0 ? 12'h030 : (k % 3 == 1 ? `QLDP_ADDR_PHASE :
         `QLDP_ADDR_LOCFG), 8'($urandom), NCH'($urandom));
      rd(`QLDP_ADDR_PHASE, NCH'($urandom));
      rd(`QLDP_ADDR_LOCFG, 1);
      rd(12'h030 + 12'(k), 1);
    end
    for (int r = 0; r < 3; r++) begin
      m = 4 << r;
      wr(`QLDP_ADDR_LOCFG, 8'(r), 1);
      wr(`QLDP_ADDR_PHASE, 8'h00, 1);
      for (int c = 1; c < NCH; c++) begin
        wr(`QLDP_ADDR_PHASE, 8'(m == 4 ? ($urandom % 8) * 2 : $urandom % 16),
           NCH'(1 << c));
      end
      repeat (20) @(posedge ref_clk);
      #1;
      lo_run(m, 2 * r + 1, p0);
    end
    wr(`QLDP_ADDR_LOCFG, 8'h09, 1);
    fall_sel = 1'b1;
    lo_run(8, 1, p0);
    repeat ($urandom % 7 + 1) @(posedge ref_clk);
    #1;
    lo_run(8, 1, p1);
    chk(p1, p0);
    report_and_stop();
  end

  initial begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end
endmodule : test_qldp_top

bind qldp_top qldp_top_sva #(.NUM_CH(NUM_CH)) i_qldp_top_sva (
  .ref_clk(ref_clk), .rstn(rstn), .reg_req(reg_req), .chan_sel(chan_sel),
  .reg_rdata(reg_rdata), .sync_pin(sync_pin), .lo_i(lo_i), .lo_q(lo_q));
